// ==== dci_pkg.sv ====
/*
  dci_pkg: shared constants and types for the daisy-chain interrupt port.
  Assumes a single 50 MHz system clock domain; the host strobes are asynchronous pins.
*/
package dci_pkg;

  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 2;

  // register selects on the address lines
  localparam logic [ADDR_W-1:0] ADDR_VECTOR  = 2'h0;
  localparam logic [ADDR_W-1:0] ADDR_COMMAND = 2'h1;
  localparam logic [ADDR_W-1:0] ADDR_STATUS  = 2'h2;
  localparam logic [ADDR_W-1:0] ADDR_SPARE   = 2'h3;

  // command register bit positions
  localparam int unsigned CMD_CLR_SERVICE = 0;
  localparam int unsigned CMD_CLR_PENDING = 1;
  localparam int unsigned CMD_SET_BLOCK   = 2;
  localparam int unsigned CMD_CLR_BLOCK   = 3;

  // status register bit positions
  localparam int unsigned STS_PENDING = 0;
  localparam int unsigned STS_SERVICE = 1;
  localparam int unsigned STS_BLOCK   = 2;
  localparam int unsigned STS_CHAIN   = 3;

  localparam logic [DATA_W-1:0] VECTOR_RST = 8'h00;
  localparam logic [DATA_W-1:0] DATA_ZERO  = 8'h00;

  // synchroniser depth, in clock edges, before logic sees a pin
  localparam int unsigned SYNC_STAGES = 2;

  // asynchronous host strobes and the chain input, all sampled together
  typedef struct packed {
    logic ce_n;
    logic rd_n;
    logic wr_n;
    logic irq_ack_n;
    logic chain_enable_in;
  } dci_pins_s;

  localparam int unsigned PINS_W = $bits(dci_pins_s);
  localparam dci_pins_s PINS_IDLE = '{ce_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, irq_ack_n: 1'b1, chain_enable_in: 1'b0};

endpackage : dci_pkg

// ==== dci_sync.sv ====
/*
  dci_sync: two-flop synchroniser for a bundle of level signals.
  Assumes each bit is a level that holds for several clocks.
*/
`timescale 1ns/1ps
module dci_sync #(
  parameter int unsigned W              = 1,
  parameter logic [W-1:0] RST_VAL       = '0
) (
  input  wire logic          i_clk_sys,
  input  wire logic          i_rst_b,
  input  wire logic [W-1:0]  i_async,
  output logic      [W-1:0]  o_sync
);

  logic [W-1:0] meta_reg;

  // meta_reg feeds only the second stage
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      meta_reg <= RST_VAL;
      o_sync   <= RST_VAL;
    end
    else
    begin
      meta_reg <= i_async;
      o_sync   <= meta_reg;
    end
  end

endmodule : dci_sync

// ==== dci_port.sv ====
/*
  dci_port: host bus port and daisy-chain interrupt logic of a peripheral.
  Assumes the host keeps address, data and acknowledge stable through each strobe,
  and that the event inputs come from logic on i_clk_sys.
*/
`timescale 1ns/1ps
// What this block does
// - drive bus during chip-selected read or acknowledge read, release otherwise
// - write strobe stores data into selected register
// - read and write together reset the chip
// - address lines pick the register reached
// - acknowledge with read places vector on bus
// - request output is open-drain, low only
// - acknowledge sets service if pending and enabled
// - chain input low: no service, no vector
// - service flag cleared only by command or chip reset
// - idle chain out follows input and service
// - acknowledge chain out low if pending or service
// - block command forces chain out low
// - chain signals active high, ordered by priority
// - pending set by event, cleared by software/completion
// - no new request during acknowledge cycle
module dci_port (
  input  wire logic                          i_clk_sys,
  input  wire logic                          i_rst_b,
  input  wire logic                          i_ce_n,
  input  wire logic                          i_rd_n,
  input  wire logic                          i_wr_n,
  input  wire logic                          i_irq_ack_n,
  input  wire logic [dci_pkg::ADDR_W-1:0]    i_register_select_lines,
  input  wire logic [dci_pkg::DATA_W-1:0]    i_host_data_bus,
  output logic      [dci_pkg::DATA_W-1:0]    o_host_data_bus,
  output logic                               o_host_data_oe,
  output logic                               o_irq_n,
  output logic                               o_irq_n_oe,
  input  wire logic                          i_chain_enable_in,
  output logic                               o_chain_enable_out,
  input  wire logic                          i_pend_set,
  input  wire logic                          i_pend_done
);
  import dci_pkg::*;

  dci_pins_s pins_async;
  dci_pins_s pins;
  logic [ADDR_W+DATA_W-1:0] addr_data_sync;

  assign pins_async = '{ce_n: i_ce_n, rd_n: i_rd_n, wr_n: i_wr_n, irq_ack_n: i_irq_ack_n,
                        chain_enable_in: i_chain_enable_in};

  // strobes and chain input share one synchroniser bundle
  dci_sync #(
    .W       (PINS_W),
    .RST_VAL (PINS_IDLE)
  ) u_sync (
    .i_clk_sys (i_clk_sys),
    .i_rst_b   (i_rst_b),
    .i_async   (pins_async),
    .o_sync    (pins)
  );

  // address and data take the same two flops as the strobes, so they line up with them
  dci_sync #(
    .W       (ADDR_W + DATA_W),
    .RST_VAL ('0)
  ) u_sync_addr_data (
    .i_clk_sys (i_clk_sys),
    .i_rst_b   (i_rst_b),
    .i_async   ({i_register_select_lines, i_host_data_bus}),
    .o_sync    (addr_data_sync)
  );

  logic              pending_flag_reg;
  logic              under_service_flag_reg;
  logic              block_lower_chain_reg;
  logic [DATA_W-1:0] vector_reg;
  logic              ack_rd_prev_reg;
  logic              wr_prev_reg;
  logic              owner_reg;

  logic              pending_flag_next;
  logic              under_service_flag_next;
  logic              block_lower_chain_next;
  logic [DATA_W-1:0] vector_next;
  logic              owner_next;
  logic [DATA_W-1:0] data_next;
  logic              data_oe_next;
  logic              irq_oe_next;
  logic              chain_out_next;

  wire in_ack       = ~pins.irq_ack_n;
  wire cei          = pins.chain_enable_in;
  wire chip_rst     = ~pins.rd_n & ~pins.wr_n;
  wire reg_rd       = ~pins.ce_n & ~pins.rd_n & pins.wr_n & ~in_ack;
  wire ack_rd       = in_ack & ~pins.rd_n & pins.wr_n;
  wire ack_rd_start = ack_rd & ~ack_rd_prev_reg;
  wire wr_cyc       = ~pins.ce_n & ~pins.wr_n & pins.rd_n & ~in_ack;
  wire wr_start     = wr_cyc & ~wr_prev_reg;

  wire [ADDR_W-1:0] sel_sync   = addr_data_sync[DATA_W +: ADDR_W];
  wire [DATA_W-1:0] wdata_sync = addr_data_sync[DATA_W-1:0];

  wire sel_vector   = (sel_sync == ADDR_VECTOR);
  wire sel_command  = (sel_sync == ADDR_COMMAND);
  wire sel_status   = (sel_sync == ADDR_STATUS);
  wire wr_vector    = wr_start & sel_vector;
  wire wr_command   = wr_start & sel_command;

  wire cmd_clr_service = wr_command & wdata_sync[CMD_CLR_SERVICE];
  wire cmd_clr_pending = wr_command & wdata_sync[CMD_CLR_PENDING];
  wire cmd_set_block   = wr_command & wdata_sync[CMD_SET_BLOCK];
  wire cmd_clr_block   = wr_command & wdata_sync[CMD_CLR_BLOCK];

  // service set is gated by the chain input, so a blocked device never claims the vector
  wire service_set = ack_rd_start & pending_flag_reg & cei;

  wire [DATA_W-1:0] status_word = {{(DATA_W-4){1'b0}}, cei, block_lower_chain_reg,
                                   under_service_flag_reg, pending_flag_reg};
  wire [DATA_W-1:0] read_mux = sel_vector ? vector_reg :
                               sel_status ? status_word : DATA_ZERO;

  // set wins over a command or done clear in the same cycle; chip reset wins over set
  assign pending_flag_next = chip_rst ? 1'b0 :
                             i_pend_set ? 1'b1 :
                             (cmd_clr_pending | i_pend_done) ? 1'b0 : pending_flag_reg;

  assign under_service_flag_next = chip_rst ? 1'b0 :
                                   service_set ? 1'b1 :
                                   cmd_clr_service ? 1'b0 : under_service_flag_reg;

  assign block_lower_chain_next = chip_rst ? 1'b0 :
                                  cmd_set_block ? 1'b1 :
                                  cmd_clr_block ? 1'b0 : block_lower_chain_reg;

  assign vector_next = chip_rst ? VECTOR_RST :
                       wr_vector ? wdata_sync : vector_reg;

  assign owner_next   = ack_rd & (owner_reg | service_set);
  assign data_oe_next = reg_rd | owner_next;
  assign data_next    = owner_next ? vector_reg : read_mux;

  // frozen during acknowledge so the chain settles before any new request
  assign irq_oe_next = in_ack ? o_irq_n_oe :
                       (pending_flag_reg & cei & ~under_service_flag_reg & ~chip_rst);

  assign chain_out_next = cei & ~under_service_flag_reg & ~block_lower_chain_reg &
                          ~(in_ack & pending_flag_reg);

  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      pending_flag_reg       <= 1'b0;
      under_service_flag_reg <= 1'b0;
      block_lower_chain_reg  <= 1'b0;
      vector_reg             <= VECTOR_RST;
      ack_rd_prev_reg        <= 1'b0;
      wr_prev_reg            <= 1'b0;
      owner_reg              <= 1'b0;
    end
    else
    begin
      pending_flag_reg       <= pending_flag_next;
      under_service_flag_reg <= under_service_flag_next;
      block_lower_chain_reg  <= block_lower_chain_next;
      vector_reg             <= vector_next;
      ack_rd_prev_reg        <= ack_rd;
      wr_prev_reg            <= wr_cyc;
      owner_reg              <= owner_next;
    end
  end

  // pin-facing outputs, all registered
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_host_data_bus    <= DATA_ZERO;
      o_host_data_oe     <= 1'b0;
      o_irq_n            <= 1'b0;
      o_irq_n_oe         <= 1'b0;
      o_chain_enable_out <= 1'b0;
    end
    else
    begin
      o_host_data_bus    <= data_next;
      o_host_data_oe     <= data_oe_next;
      o_irq_n            <= 1'b0;
      o_irq_n_oe         <= irq_oe_next;
      o_chain_enable_out <= chain_out_next;
    end
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);

  sequence s_ack_read_claim;
    ack_rd_start && pending_flag_reg && cei;
  endsequence

  a_read_drives_bus: assert property (reg_rd |=> o_host_data_oe && o_host_data_bus == $past(read_mux))
    else $error("register read did not drive the bus");
  a_bus_released: assert property (!reg_rd && !ack_rd |=> !o_host_data_oe)
    else $error("bus driven outside a read");
  a_write_vector: assert property (wr_vector && !chip_rst |=> vector_reg == $past(wdata_sync))
    else $error("vector write not captured");
  a_chip_reset: assert property (chip_rst |=> !pending_flag_reg && !under_service_flag_reg
                                 && !block_lower_chain_reg && vector_reg == VECTOR_RST)
    else $error("combined strobe did not reset");
  a_vector_claim: assert property (s_ack_read_claim |=> under_service_flag_reg && o_host_data_oe
                                   && o_host_data_bus == $past(vector_reg))
    else $error("acknowledge did not claim vector");
  a_irq_open_drain: assert property (o_irq_n == 1'b0)
    else $error("request pin driven high");
  a_chain_low_no_claim: assert property (ack_rd_start && !cei && !under_service_flag_reg
                                         |=> !under_service_flag_reg && !o_host_data_oe)
    else $error("blocked device claimed acknowledge");
  a_service_clear: assert property ($fell(under_service_flag_reg) |-> $past(cmd_clr_service || chip_rst))
    else $error("service flag cleared without command");
  a_chain_idle: assert property (!in_ack && !block_lower_chain_reg
                                 |=> o_chain_enable_out == $past(cei && !under_service_flag_reg))
    else $error("idle chain output wrong");
  a_chain_ack: assert property (in_ack && (pending_flag_reg || under_service_flag_reg || !cei)
                                |=> !o_chain_enable_out)
    else $error("chain open during acknowledge");
  a_chain_block: assert property (block_lower_chain_reg |=> !o_chain_enable_out)
    else $error("block command did not close chain");
  a_pending_set: assert property (i_pend_set && !chip_rst |=> pending_flag_reg)
    else $error("pending event lost");
  a_no_new_irq: assert property (in_ack && !o_irq_n_oe |=> !o_irq_n_oe)
    else $error("request raised during acknowledge");
  a_irq_request: assert property (!in_ack && !chip_rst |=> o_irq_n_oe == $past(pending_flag_reg
                                  && cei && !under_service_flag_reg))
    else $error("request output wrong");

endmodule : dci_port

// ==== dci_bus_model.sv ====
/*
  dci_bus_model: board wiring seen by the host around one port.
  Assumes one device on the data bus and a pull-up on the request line.
*/
`timescale 1ns/1ps
module dci_bus_model (
  input  wire logic                      i_clk_sys,
  input  wire logic [dci_pkg::DATA_W-1:0] i_dev_data,
  input  wire logic                      i_dev_data_oe,
  input  wire logic                      i_dev_irq_n,
  input  wire logic                      i_dev_irq_n_oe,
  output logic      [dci_pkg::DATA_W-1:0] o_bus_level,
  output logic                           o_irq_level
);
  import dci_pkg::*;
  logic [DATA_W-1:0] last_reg;
  always_ff @(posedge i_clk_sys)
  begin
    if (i_dev_data_oe)
      last_reg <= i_dev_data;
  end
  // no keeper: a released bus reads back inverted, so a stale byte never passes for a read
  assign o_bus_level = i_dev_data_oe ? i_dev_data : ~last_reg;
  assign o_irq_level = i_dev_irq_n_oe ? i_dev_irq_n : 1'b1;
endmodule : dci_bus_model

// ==== daisy_chain_interrupt_port_tb_top.sv ====
/*
  daisy_chain_interrupt_port_tb_top: directed bench for dci_port.
  Assumes the 2-edge strobe latency of the two-flop synchronisers.
*/
`timescale 1ns/1ps
module daisy_chain_interrupt_port_tb_top;
  import dci_pkg::*;
  logic clk = 0, rst_b = 0, ce_n = 1, rd_n = 1, wr_n = 1, ack_n = 1;
  logic chain_in = 0, pend_set = 0, pend_done = 0;
  logic [1:0] sel = 2'h0;
  logic [7:0] wdata = 8'h00, dout, bus, d;
  logic doe, irq_n, irq_oe, chain_out, irq_lvl, oe;
  int bad_count = 0, comparisons = 0;
  always #10 clk = ~clk;
  dci_port i_dut (.i_clk_sys(clk), .i_rst_b(rst_b), .i_ce_n(ce_n), .i_rd_n(rd_n), .i_wr_n(wr_n),
    .i_irq_ack_n(ack_n), .i_register_select_lines(sel), .i_host_data_bus(wdata), .o_host_data_bus(dout),
    .o_host_data_oe(doe), .o_irq_n(irq_n), .o_irq_n_oe(irq_oe), .i_chain_enable_in(chain_in),
    .o_chain_enable_out(chain_out), .i_pend_set(pend_set), .i_pend_done(pend_done));
  dci_bus_model i_bus (.i_clk_sys(clk), .i_dev_data(dout), .i_dev_data_oe(doe), .i_dev_irq_n(irq_n),
    .i_dev_irq_n_oe(irq_oe), .o_bus_level(bus), .o_irq_level(irq_lvl));
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic bus_rd(input logic [1:0] a, output logic [7:0] v);
    int k;
    sel = a;
    ce_n = 0;
    rd_n = 0;
    for (k = 0; k < 8 && doe !== 1'b1; k++)
      step(1);
    if (k == 8)
    begin
      bad_count++;
      report_and_stop();
    end
    v = bus;
    rd_n = 1;
    ce_n = 1;
    step(4);
    check("bus released", {7'h0, doe}, 8'h00);
  endtask : bus_rd
  task automatic bus_wr(input logic [1:0] a, input logic [7:0] v);
    sel = a;
    wdata = v;
    ce_n = 0;
    wr_n = 0;
    step(4);
    wr_n = 1;
    ce_n = 1;
    step(4);
  endtask : bus_wr
  task automatic pulse_set;
    pend_set = 1;
    step(1);
    pend_set = 0;
    step(3);
  endtask : pulse_set
  // acknowledge with read; captures chain out before the read strobe
  task automatic ack_cycle(output logic c, output logic o, output logic [7:0] v);
    ack_n = 0;
    step(4);
    c = chain_out;
    rd_n = 0;
    step(5);
    o = doe;
    v = bus;
    rd_n = 1;
    ack_n = 1;
    step(4);
  endtask : ack_cycle
  task automatic t_reset;
    check("chain after reset", {7'h0, chain_out}, 8'h00);
    check("irq after reset", {7'h0, irq_lvl}, 8'h01);
    chain_in = 1;
    step(4);
    check("chain idle", {7'h0, chain_out}, 8'h01);
    $display("test reset done");
  endtask : t_reset
  task automatic t_regs;
    bus_wr(ADDR_VECTOR, 8'ha5);
    bus_rd(ADDR_VECTOR, d);
    check("vector", d, 8'ha5);
    bus_wr(ADDR_STATUS, 8'hff);
    bus_rd(ADDR_STATUS, d);
    check("status", d, 8'h08);
    bus_rd(ADDR_SPARE, d);
    check("spare", d, 8'h00);
    bus_rd(ADDR_COMMAND, d);
    check("command reads zero", d, 8'h00);
    $display("test regs done");
  endtask : t_regs
  task automatic t_ack;
    logic c;
    ack_n = 0;
    step(3);
    pulse_set();
    check("irq in ack", {7'h0, irq_lvl}, 8'h01);
    check("chain in ack", {7'h0, chain_out}, 8'h00);
    ack_n = 1;
    step(4);
    check("irq raised", {7'h0, irq_lvl}, 8'h00);
    check("chain pending", {7'h0, chain_out}, 8'h01);
    ack_cycle(c, oe, d);
    check("ack chain", {7'h0, c}, 8'h00);
    check("ack drive", {7'h0, oe}, 8'h01);
    check("ack vector", d, 8'ha5);
    check("chain served", {7'h0, chain_out}, 8'h00);
    check("irq served", {7'h0, irq_lvl}, 8'h01);
    bus_rd(ADDR_STATUS, d);
    check("status served", d, 8'h0b);
    bus_wr(ADDR_COMMAND, 8'h01);
    bus_rd(ADDR_STATUS, d);
    check("service cleared", d, 8'h09);
    check("chain back", {7'h0, chain_out}, 8'h01);
    bus_wr(ADDR_COMMAND, 8'h02);
    bus_rd(ADDR_STATUS, d);
    check("pending cleared", d, 8'h08);
    $display("test ack done");
  endtask : t_ack
  task automatic t_chain_low;
    logic c;
    pulse_set();
    chain_in = 0;
    step(4);
    check("irq chain low", {7'h0, irq_lvl}, 8'h01);
    check("chain low", {7'h0, chain_out}, 8'h00);
    ack_cycle(c, oe, d);
    check("no drive", {7'h0, oe}, 8'h00);
    check("ack chain low", {7'h0, c}, 8'h00);
    bus_rd(ADDR_STATUS, d);
    check("no service", d, 8'h01);
    chain_in = 1;
    pend_done = 1;
    step(1);
    pend_done = 0;
    step(4);
    bus_rd(ADDR_STATUS, d);
    check("done clears", d, 8'h08);
    $display("test chain low done");
  endtask : t_chain_low
  task automatic t_block;
    bus_wr(ADDR_COMMAND, 8'h04);
    check("blocked", {7'h0, chain_out}, 8'h00);
    bus_wr(ADDR_COMMAND, 8'h08);
    check("unblocked", {7'h0, chain_out}, 8'h01);
    bus_wr(ADDR_COMMAND, 8'h04);
    pulse_set();
    ce_n = 0;
    rd_n = 0;
    wr_n = 0;
    step(4);
    rd_n = 1;
    wr_n = 1;
    ce_n = 1;
    step(4);
    bus_rd(ADDR_VECTOR, d);
    check("vector reset", d, 8'h00);
    bus_rd(ADDR_STATUS, d);
    check("block reset", d, 8'h08);
    check("irq after chip reset", {7'h0, irq_lvl}, 8'h01);
    check("chain after chip reset", {7'h0, chain_out}, 8'h01);
    $display("test block done");
  endtask : t_block
  initial
  begin
    step(12);
    rst_b = 1;
    step(3);
    t_reset();
    t_regs();
    t_ack();
    t_chain_low();
    t_block();
    report_and_stop();
  end
endmodule : daisy_chain_interrupt_port_tb_top
